// [rtl/chan_ctrl_regs.vh]
// register map, field positions and timing constants of the channel controller
`ifndef CHAN_CTRL_REGS_VH
`define CHAN_CTRL_REGS_VH

// register offsets on the plain software port
`define CC_ADDR_W        3
`define CC_OFS_CTRL      3'h0
`define CC_OFS_STATUS    3'h1
`define CC_OFS_MADDR     3'h2
`define CC_OFS_WDATA     3'h3
`define CC_OFS_RDATA     3'h4
`define CC_OFS_TIMEOUT   3'h5

// control register fields (write)
`define CC_CTRL_GO       0
`define CC_CTRL_READ     1
`define CC_CTRL_WRITE    2
`define CC_CTRL_PWR_OK   3
`define CC_CTRL_ABORT    4

// status register fields (read; writing a one clears a sticky bit)
`define CC_STAT_BUSY     0
`define CC_STAT_DONE     1
`define CC_STAT_NXM      2
`define CC_STAT_GRANTED  3

// reset values
`define CC_TIMEOUT_RST   16'h0100
`define CC_CTRL_RST      5'h08

// timing: clock period and the nonexistent memory wait, in ns
`define CC_CLK_NS        4
`define CC_NXM_WAIT_NS   1024
`define CC_NXM_CYCLES    ((`CC_NXM_WAIT_NS + `CC_CLK_NS - 1) / `CC_CLK_NS)

`endif

// [rtl/chan_ctrl.v]
// data channel controller that gains memory access through the port multiplexor
`timescale 1ns/100ps
`include "chan_ctrl_regs.vh"

// Summary of operation
// - controller holds its request low until it is granted.
// - granted controller sends cycle request and typed address, relayed to memory.
// - on address accept in a plain write, or on read restart in a read-modify-write, send write restart with write data.
// - on nonexistent memory pulse own abort line; multiplexor then disconnects.
module chan_ctrl
#(
  parameter DATA_W  = 36,          // memory word width
  parameter ADDR_W  = 18,          // memory address width
  parameter TMO_W   = 16,          // width of the nonexistent memory counter
  parameter NXM_DEF = `CC_NXM_CYCLES // default wait for address accept
)
(
  input  wire                  CLK_I,        // system clock, 250 MHz
  input  wire                  NRST_I,       // synchronous reset, active low
  input  wire [`CC_ADDR_W-1:0] ADR_I,        // register address
  input  wire [31:0]           WDAT_I,       // register write data
  input  wire                  WE_I,         // write strobe
  input  wire                  RE_I,         // read strobe
  output wire [31:0]           RDAT_O,       // read data, cycle after strobe
  output wire                  REQ_N_O,      // port request, active low
  output wire                  PWR_OK_N_O,   // processor power ok, active low
  input  wire                  GRANT_I,      // port grant from multiplexor
  output wire                  CYC_REQ_O,    // cycle request on mux bus
  output wire [ADDR_W-1:0]     MADDR_O,      // address word on mux bus
  output wire                  MUX_RD_O,     // read type with the address
  output wire                  MUX_WR_O,     // write type with the address
  input  wire                  ACCEPT_I,     // address accept relayed back
  input  wire                  RD_RESTART_I, // read restart relayed back
  input  wire [DATA_W-1:0]     RDATA_I,      // read word on mux bus
  output wire                  WR_RESTART_O, // write restart pulse
  output wire [DATA_W-1:0]     WDATA_O,      // write word on mux bus
  output wire                  ABORT_O       // port abort pulse
);

  // one-hot states of the access sequencer
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_REQ   = 7'h02;
  localparam [6:0] S_ADDR  = 7'h04;
  localparam [6:0] S_READ  = 7'h08;
  localparam [6:0] S_WRITE = 7'h10;
  localparam [6:0] S_WREND = 7'h20;
  localparam [6:0] S_ABORT = 7'h40;

  reg [6:0]        state_r;
  reg [6:0]        state_nxt;
  reg              pwr_ok_r;
  reg              op_rd_r;
  reg              op_wr_r;
  reg [ADDR_W-1:0] maddr_r;
  reg [DATA_W-1:0] wdata_r;
  reg [DATA_W-1:0] rdata_r;
  reg [TMO_W-1:0]  tmo_lim_r;
  reg [TMO_W-1:0]  tmo_cnt_r;
  reg              done_r;
  reg              nxm_r;
  reg              granted_r;
  reg              accepted_r;
  reg [31:0]       rd_out_r;
  reg              req_n_r;
  reg              cyc_r;
  reg              wr_rs_r;
  reg              abort_r;
  reg              abort_pend_r;

  wire ctrl_we   = WE_I && (ADR_I == `CC_OFS_CTRL);
  wire stat_we   = WE_I && (ADR_I == `CC_OFS_STATUS);
  wire go        = ctrl_we && WDAT_I[`CC_CTRL_GO] && (state_r == S_IDLE);
  // an abort written while still requesting is parked until the grant
  wire abort_wr  = ctrl_we && WDAT_I[`CC_CTRL_ABORT];
  wire sw_abort  = abort_wr && (state_r != S_IDLE) && (state_r != S_REQ);
  wire tmo_hit   = (tmo_cnt_r == tmo_lim_r);
  wire busy      = (state_r != S_IDLE);
  wire fin_ok    = (state_r == S_WREND) || ((state_r == S_READ) && RD_RESTART_I && !op_wr_r);
  // a parked abort fires once the cycle request has gone out
  wire go_abort  = sw_abort ||
                   ((state_r == S_ADDR) && !accepted_r && (tmo_hit || abort_pend_r));

  // sequencer next state
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE:
        if (go)
          state_nxt = S_REQ;
      S_REQ:
        if (GRANT_I)
          state_nxt = S_ADDR;
      S_ADDR:
        if (go_abort)
          state_nxt = S_ABORT;
        else if (ACCEPT_I || accepted_r)
          state_nxt = op_rd_r ? S_READ : S_WRITE;
      S_READ:
        if (sw_abort)
          state_nxt = S_ABORT;
        else if (RD_RESTART_I)
          state_nxt = op_wr_r ? S_WRITE : S_IDLE;          // rmw keeps the port
      S_WRITE:
        state_nxt = S_WREND;
      S_WREND:
        state_nxt = S_IDLE;
      S_ABORT:
        state_nxt = S_IDLE;
      default:
        state_nxt = S_IDLE;
    endcase
  end

  // state register and software-visible control
  always @(posedge CLK_I)
  begin
    if (!NRST_I)
    begin
      state_r   <= S_IDLE;
      pwr_ok_r  <= 1'b1;
      op_rd_r   <= 1'b0;
      op_wr_r   <= 1'b0;
      maddr_r   <= {ADDR_W{1'b0}};
      wdata_r   <= {DATA_W{1'b0}};
      tmo_lim_r <= NXM_DEF[TMO_W-1:0];
    end
    else
    begin
      state_r <= state_nxt;
      if (ctrl_we)
        pwr_ok_r <= WDAT_I[`CC_CTRL_PWR_OK];
      // the operation type is latched only when a new access starts
      if (go)
      begin
        op_rd_r <= WDAT_I[`CC_CTRL_READ];
        op_wr_r <= WDAT_I[`CC_CTRL_WRITE];
      end
      // address and data are locked while an access is under way
      if (WE_I && (ADR_I == `CC_OFS_MADDR) && !busy)
        maddr_r <= WDAT_I[ADDR_W-1:0];
      if (WE_I && (ADR_I == `CC_OFS_WDATA) && !busy)
        wdata_r <= {{(DATA_W-32){1'b0}}, WDAT_I};
      if (WE_I && (ADR_I == `CC_OFS_TIMEOUT))
        tmo_lim_r <= WDAT_I[TMO_W-1:0];
    end
  end

  // nonexistent memory watchdog: runs while waiting for address accept
  // the count stops at the limit, so a hung memory gives one abort only;
  // a small limit trades false aborts on slow memory for a quicker release
  always @(posedge CLK_I)
  begin
    if (!NRST_I)
      tmo_cnt_r <= {TMO_W{1'b0}};
    else if (state_r == S_ADDR && !tmo_hit)
      tmo_cnt_r <= tmo_cnt_r + {{(TMO_W-1){1'b0}}, 1'b1};
    else if (state_r != S_ADDR)
      tmo_cnt_r <= {TMO_W{1'b0}};
  end

  // accept may pulse for one cycle only, so remember it
  always @(posedge CLK_I)
  begin
    if (!NRST_I)
      accepted_r <= 1'b0;
    else if (state_r == S_ADDR && ACCEPT_I)
      accepted_r <= 1'b1;
    else if (state_r != S_ADDR)
      accepted_r <= 1'b0;
  end

  // parked abort: dropping the request before the grant would leave the
  // multiplexor granting a port that never sends a cycle, so the request
  // stays low and the abort pulse follows the grant instead
  always @(posedge CLK_I)
  begin
    if (!NRST_I)
      abort_pend_r <= 1'b0;
    else if (state_r == S_REQ && abort_wr)
      abort_pend_r <= 1'b1;
    else if (state_r != S_REQ && state_r != S_ADDR)
      abort_pend_r <= 1'b0;
  end

  // captured read word, taken with the read restart pulse
  always @(posedge CLK_I)
  begin
    if (!NRST_I)
      rdata_r <= {DATA_W{1'b0}};
    else if (state_r == S_READ && RD_RESTART_I)
      rdata_r <= RDATA_I;
  end

  // sticky status bits; a hardware set wins over a software clear
  // so an event landing in the cycle of a clear is never lost
  always @(posedge CLK_I)
  begin
    if (!NRST_I)
    begin
      done_r    <= 1'b0;
      nxm_r     <= 1'b0;
      granted_r <= 1'b0;
    end
    else
    begin
      if (fin_ok)
        done_r <= 1'b1;
      else if (stat_we && WDAT_I[`CC_STAT_DONE])
        done_r <= 1'b0;
      if (go_abort)
        nxm_r <= 1'b1;
      else if (stat_we && WDAT_I[`CC_STAT_NXM])
        nxm_r <= 1'b0;
      if (state_r == S_REQ && GRANT_I)
        granted_r <= 1'b1;
      else if (stat_we && WDAT_I[`CC_STAT_GRANTED])
        granted_r <= 1'b0;
    end
  end

  // multiplexor-side request, cycle, write restart and abort outputs, all from flip-flops
  // registering them keeps decode glitches off the cable side
  always @(posedge CLK_I)
  begin
    if (!NRST_I)
    begin
      req_n_r <= 1'b1;
      cyc_r   <= 1'b0;
      wr_rs_r <= 1'b0;
      abort_r <= 1'b0;
    end
    else
    begin
      // request held low from start until grant is seen
      req_n_r <= !(state_nxt == S_REQ);
      // cycle request stands with the address until accept
      cyc_r   <= (state_nxt == S_ADDR) && !(ACCEPT_I || accepted_r);
      // write restart goes out together with the write word
      wr_rs_r <= (state_nxt == S_WRITE);
      abort_r <= (state_nxt == S_ABORT);
    end
  end

  // register read port, answer one cycle after the strobe
  // unmapped offsets read as zero rather than aliasing a register
  always @(posedge CLK_I)
  begin
    if (!NRST_I)
      rd_out_r <= 32'h00000000;
    else if (RE_I)
    begin
      if (ADR_I == `CC_OFS_CTRL)
        rd_out_r <= {27'h0000000, 1'b0, pwr_ok_r, op_wr_r, op_rd_r, 1'b0};
      else if (ADR_I == `CC_OFS_STATUS)
        rd_out_r <= {28'h0000000, granted_r, nxm_r, done_r, busy};
      else if (ADR_I == `CC_OFS_MADDR)
        rd_out_r <= {{(32-ADDR_W){1'b0}}, maddr_r};
      else if (ADR_I == `CC_OFS_WDATA)
        rd_out_r <= wdata_r[31:0];
      else if (ADR_I == `CC_OFS_RDATA)
        rd_out_r <= rdata_r[31:0];
      else if (ADR_I == `CC_OFS_TIMEOUT)
        rd_out_r <= {{(32-TMO_W){1'b0}}, tmo_lim_r};
      else
        rd_out_r <= 32'h00000000;                           // unmapped reads zero
    end
    else
      rd_out_r <= 32'h00000000;
  end

  assign RDAT_O       = rd_out_r;
  assign REQ_N_O      = req_n_r;
  assign PWR_OK_N_O   = !pwr_ok_r;
  // address and type travel with the cycle request
  assign CYC_REQ_O    = cyc_r;
  assign MADDR_O      = maddr_r;
  assign MUX_RD_O     = op_rd_r & busy;
  assign MUX_WR_O     = op_wr_r & busy;
  assign WR_RESTART_O = wr_rs_r;
  // write word driven only while the write phase is open
  assign WDATA_O      = (state_r == S_WRITE || state_r == S_WREND) ? wdata_r : {DATA_W{1'b0}};
  assign ABORT_O      = abort_r;

endmodule

// [verif/chan_ctrl_sva.sv]
// link pin checks for the channel controller
`timescale 1ns/100ps
module chan_ctrl_sva
(
  input wire CLK_I,        // clock
  input wire NRST_I,       // reset, low
  input wire REQ_N_O,      // request, low
  input wire GRANT_I,      // grant
  input wire CYC_REQ_O,    // cycle request
  input wire ACCEPT_I,     // address accept
  input wire MUX_RD_O,     // read type
  input wire MUX_WR_O,     // write type
  input wire WR_RESTART_O, // write restart
  input wire ABORT_O       // abort
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  // request, grant and cycle order on the port
  a_req_held: assert property (!REQ_N_O && !GRANT_I |=> !REQ_N_O)
    else $error("request dropped before grant");
  a_cyc_grant: assert property (!REQ_N_O && GRANT_I |=> CYC_REQ_O && REQ_N_O)
    else $error("no cycle request after grant");
  // plain write: restart in the cycle after accept is seen, one cycle long
  a_wr_restart: assert property (CYC_REQ_O && ACCEPT_I && MUX_WR_O && !MUX_RD_O
    |=> WR_RESTART_O ##1 !WR_RESTART_O)
    else $error("write restart misplaced");
  a_abort_drop: assert property (ABORT_O |=> !ABORT_O && REQ_N_O && !CYC_REQ_O)
    else $error("abort not a single pulse");
  c_write: cover property (WR_RESTART_O && !MUX_RD_O);
  c_rmw: cover property (WR_RESTART_O && MUX_RD_O);
  c_abort: cover property (ABORT_O);
endmodule

// [verif/mux_model.sv]
// behavioural multiplexor and memory seen from one port
`timescale 1ns/100ps
module mux_model
#(
  parameter        POR_CYC = 4,    // settle time, shortened
  parameter        DLY_CYC = 17,   // 65 ns rounded up to 4 ns cycles
  parameter [35:0] RD_WORD = 36'h0 // word the memory returns
)
(
  input  wire        clk,    // clock
  input  wire        req_n,  // request, low
  input  wire        pwr_n,  // power ok, low
  input  wire        cyc,    // cycle request
  input  wire [17:0] addr,   // address word
  input  wire        rd,     // read type
  input  wire        wr,     // write type
  input  wire        wr_rs,  // write restart
  input  wire [35:0] wdata,  // write word
  input  wire        abort,  // port abort
  input  wire        nxm,    // no memory answers
  input  wire [3:0]  dly,    // extra accept delay
  output reg         grant,  // port grant
  output reg         accept, // address accept
  output reg         rd_rs,  // read restart
  output reg  [35:0] rdata,  // read word
  output reg  [17:0] acap,   // address seen
  output reg  [35:0] wcap    // write word seen
);
  reg     rdy;
  reg     rd_r;
  reg     wr_r;
  integer i;
  // no grant before the supplies have settled
  initial
  begin
    rdy = 1'b0;
    grant = 1'b0;
    accept = 1'b0;
    rd_rs = 1'b0;
    rdata = ~RD_WORD;
    acap = 18'h0;
    wcap = 36'h0;
    repeat (POR_CYC) @(posedge clk);
    rdy <= 1'b1;
  end
  // one access at a time; busy lasts until the delayed clear
  always
  begin
    @(posedge clk);
    if (rdy && !req_n && !pwr_n)
    begin
      grant <= 1'b1;
      for (i = 0; i < 50 && !cyc; i = i + 1)
        @(posedge clk);
      acap <= addr;
      rd_r = rd;
      wr_r = wr;
      repeat (dly) @(posedge clk);
      if (nxm)
      begin
        for (i = 0; i < 600 && !abort; i = i + 1)
          @(posedge clk);
      end
      else
      begin
        accept <= 1'b1;
        @(posedge clk);
        accept <= 1'b0;
        if (rd_r)
        begin
          rd_rs <= 1'b1;
          rdata <= RD_WORD;
          @(posedge clk);
          rd_rs <= 1'b0;
          rdata <= ~RD_WORD; // released bus shows the inverse
        end
        for (i = 0; i < 50 && wr_r && !wr_rs; i = i + 1)
          @(posedge clk);
        if (wr_r)
          wcap <= wdata;
      end
      grant <= 1'b0;
      repeat (DLY_CYC) @(posedge clk);
    end
  end
endmodule

// [verif/testbench.sv]
// self-checking bench of the channel controller
`timescale 1ns/100ps
`include "chan_ctrl_regs.vh"
`define CHK(n, e, g) begin checks_done = checks_done + 1; if ((g) !== (e)) begin \
  error_cnt = error_cnt + 1; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
  localparam [35:0] RD_WORD = 36'h9_8765_4321;
  reg         clk, nrst, we, re, nxm;
  reg  [2:0]  adr;
  reg  [3:0]  dly;
  reg  [31:0] wdat, sts;
  wire        req_n, pwr_n, grant, cyc, mrd, mwr, accept, rd_rs, wr_rs, abort;
  wire [17:0] maddr, acap;
  wire [31:0] rdat;
  wire [35:0] rdata, wdata, wcap;
  integer     error_cnt, checks_done;
  chan_ctrl u_chan_ctrl (.CLK_I(clk), .NRST_I(nrst), .ADR_I(adr), .WDAT_I(wdat), .WE_I(we),
    .RE_I(re), .RDAT_O(rdat), .REQ_N_O(req_n), .PWR_OK_N_O(pwr_n), .GRANT_I(grant),
    .CYC_REQ_O(cyc), .MADDR_O(maddr), .MUX_RD_O(mrd), .MUX_WR_O(mwr), .ACCEPT_I(accept),
    .RD_RESTART_I(rd_rs), .RDATA_I(rdata), .WR_RESTART_O(wr_rs), .WDATA_O(wdata),
    .ABORT_O(abort));
  mux_model #(.RD_WORD(RD_WORD)) u_mux_model (.clk(clk), .req_n(req_n), .pwr_n(pwr_n),
    .cyc(cyc), .addr(maddr), .rd(mrd), .wr(mwr), .wr_rs(wr_rs), .wdata(wdata),
    .abort(abort), .nxm(nxm), .dly(dly), .grant(grant), .accept(accept), .rd_rs(rd_rs),
    .rdata(rdata), .acap(acap), .wcap(wcap));
  // register port, one strobe cycle each
  task wreg(input [2:0] a, input [31:0] d);
  begin
    @(posedge clk);
    adr <= a;
    wdat <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  end
  endtask
  task rreg(input [2:0] a, output [31:0] d);
  begin
    @(posedge clk);
    adr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdat;
  end
  endtask
  // start an access and poll status; a bounded poll ends the run on a hang
  task go(input [31:0] c, input integer b);
    integer n;
  begin
    wreg(`CC_OFS_STATUS, 32'hf);
    wreg(`CC_OFS_CTRL, c);
    sts = 32'h0;
    for (n = 0; n < 100 && sts[b] !== 1'b1; n = n + 1)
      rreg(`CC_OFS_STATUS, sts);
    `CHK("status", 1'b1, sts[b])
    if (sts[b] !== 1'b1)
      results;
  end
  endtask
  task t_reset;
    reg [31:0] d;
  begin
    `CHK("req_n", 1'b1, req_n)
    `CHK("pwr_n", 1'b0, pwr_n)
    rreg(`CC_OFS_TIMEOUT, d);
    `CHK("timeout", 32'h0000_0100, d)
    rreg(3'h7, d);
    `CHK("unmapped", 32'h0, d)
  end
  endtask
  task t_read;
    reg [31:0] d;
  begin
    wreg(`CC_OFS_MADDR, 32'h0002_a5c3);
    go(32'hb, `CC_STAT_DONE);
    rreg(`CC_OFS_RDATA, d);
    `CHK("read word", RD_WORD[31:0], d)
    `CHK("address", 18'h2_a5c3, acap)
  end
  endtask
  task t_write;
  begin
    dly <= 4'h5;
    wreg(`CC_OFS_WDATA, 32'h5a5a_1234);
    go(32'hd, `CC_STAT_DONE);
    `CHK("write word", 36'h0_5a5a_1234, wcap)
  end
  endtask
  task t_rmw;
    reg [31:0] d;
  begin
    // mid-run reset wipes the captured word, so the read half must refill it
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    rreg(`CC_OFS_RDATA, d);
    `CHK("rdata reset", 32'h0, d)
    dly <= 4'h0;
    wreg(`CC_OFS_WDATA, 32'h0f0f_c3c3);
    go(32'hf, `CC_STAT_DONE);
    rreg(`CC_OFS_RDATA, d);
    `CHK("rmw read", RD_WORD[31:0], d)
    `CHK("rmw write", 36'h0_0f0f_c3c3, wcap)
  end
  endtask
  // software abort, parked until the grant if it comes early
  task t_abort;
    reg [31:0] d;
    integer    n;
  begin
    nxm <= 1'b1;
    wreg(`CC_OFS_STATUS, 32'hf);
    wreg(`CC_OFS_CTRL, 32'hb);
    wreg(`CC_OFS_CTRL, 32'h18);
    d = 32'h0;
    for (n = 0; n < 100 && d[`CC_STAT_NXM] !== 1'b1; n = n + 1)
      rreg(`CC_OFS_STATUS, d);
    `CHK("sw abort", 1'b1, d[`CC_STAT_NXM])
    `CHK("abort release", 1'b1, req_n)
    nxm <= 1'b0;
  end
  endtask
  task t_nxm;
  begin
    nxm <= 1'b1;
    wreg(`CC_OFS_TIMEOUT, 32'h8);
    go(32'hb, `CC_STAT_NXM);
    nxm <= 1'b0;
    `CHK("released", 1'b1, req_n)
  end
  endtask
  task results;
  begin
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    {nrst, we, re, nxm, adr, dly, wdat} = 0;
    error_cnt = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_read;
    t_write;
    t_rmw;
    t_abort;
    t_nxm;
    results;
  end
endmodule
bind chan_ctrl chan_ctrl_sva u_chan_ctrl_sva (.CLK_I(CLK_I), .NRST_I(NRST_I),
  .REQ_N_O(REQ_N_O), .GRANT_I(GRANT_I), .CYC_REQ_O(CYC_REQ_O), .ACCEPT_I(ACCEPT_I),
  .MUX_RD_O(MUX_RD_O), .MUX_WR_O(MUX_WR_O), .WR_RESTART_O(WR_RESTART_O), .ABORT_O(ABORT_O));
